// [core/acs_pkg.sv]
package acs_pkg;
	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int SEL_HI = 7;
	localparam int SEL_LO = 5;
	localparam int GAIN_BIT = 4;
	localparam int RATE_HI = 3;
	localparam int RATE_LO = 2;
	localparam int MODE_BIT = 1;
	localparam int REF_BIT = 0;
	localparam int READY_BIT = 7;
	localparam logic [6:0] STATUS_RSVD = 7'h00;
	localparam logic [3:0] FLUSH_CYCLES = 4'h2;
	typedef enum logic [1:0] {ACS_IDLE, ACS_CONV, ACS_OFF} acs_state_t;
endpackage

// [core/acs_mux_decode.sv]
`timescale 1ns/10ps
// Decodes the input select code into positive and negative input choices.
module acs_mux_decode (
	input wire logic [2:0] input_select,
	output logic [1:0] positive_input,
	output logic [1:0] negative_input,
	output logic to_analog_ground
);
	always_comb begin
		to_analog_ground = 1'b0;
		unique case (input_select)
			3'h0: begin
				positive_input = 2'h0;
				negative_input = 2'h1;
			end
			3'h1: begin
				positive_input = 2'h2;
				negative_input = 2'h3;
			end
			3'h2: begin
				positive_input = 2'h1;
				negative_input = 2'h2;
			end
			3'h7: begin
				positive_input = 2'h3;
				negative_input = 2'h0;
				to_analog_ground = 1'b1;
			end
			default: begin
				positive_input = 2'(input_select - 3'h3);
				negative_input = 2'h0;
				to_analog_ground = 1'b1;
			end
		endcase
	end
endmodule

// [core/acs_regs.sv]
`timescale 1ns/10ps
// Operation
// R1: Config at address zero, resets to zero.
// R2: Bits 7:5 select the input pair.
// R3: Bit 4 selects gain one or four.
// R4: Bits 3:2 select output data rate.
// R5: Bit 1 selects single-shot or continuous.
// R6: Bit 0 selects internal or external reference.
// R7: Status at address one, bit 7 ready.
// R8: Reading conversion data clears ready bit.
// R9: Ready reads zero after reset.
// R10: Host ignores status bits 6 to 0.
// R11: Registers reached only via read/write commands.
// R12: Config write resets filter, restarts conversion.
// R13: Registers held during power-down.
// R14: Status register writes are ignored.
module acs_regs (
	input wire logic mclk,
	input wire logic reset,
	input wire logic register_read_cmd,
	input wire logic register_write_cmd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic data_read,
	input wire logic conv_done,
	input wire logic start_cmd,
	input wire logic powerdown_cmd,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic [2:0] input_select,
	output logic [1:0] positive_input,
	output logic [1:0] negative_input,
	output logic to_analog_ground,
	output logic gain_four,
	output logic [1:0] rate_select,
	output logic conversion_mode_select,
	output logic ref_external,
	output logic filter_reset,
	output logic converting,
	output logic powered_down,
	output logic result_ready_flag
);
	logic [7:0] config_r;
	logic ready_r;
	logic [7:0] rd_data_r;
	logic rd_valid_r;
	logic filter_reset_r;
	logic [3:0] flush_cnt_r;
	logic [1:0] pos_r;
	logic [1:0] neg_r;
	logic analog_ground_r;
	logic [1:0] pos_nxt;
	logic [1:0] neg_nxt;
	logic analog_ground_nxt;
	acs_pkg::acs_state_t state_r;
	logic cfg_wr;

	////////////////////////////////////////////////////////////////////////////
	// Address decode shared by the write and read paths, so that both agree on
	// which register an address selects.
	function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] target);
		addr_hit = addr == target;
	endfunction

	// Only the configuration address is writable; a write to the status address
	// falls through and changes nothing.
	assign cfg_wr = register_write_cmd && addr_hit(reg_addr, acs_pkg::ADDR_CONFIG); // R11 R14

	////////////////////////////////////////////////////////////////////////////
	// Configuration register; only a config write changes it, power-down holds it.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			config_r <= acs_pkg::CONFIG_RESET; // R1
		end else if (cfg_wr) begin
			config_r <= wr_data; // R11 R13
		end
	end

	acs_mux_decode u_mux (
		.input_select(config_r[acs_pkg::SEL_HI:acs_pkg::SEL_LO]),
		.positive_input(pos_nxt),
		.negative_input(neg_nxt),
		.to_analog_ground(analog_ground_nxt)
	);

	// The registered decode resets to the pair that the all-zero select code picks,
	// so the outputs agree with the configuration from the first cycle.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pos_r <= 2'h0;
			neg_r <= 2'h1;
			analog_ground_r <= 1'b0;
		end else begin
			pos_r <= pos_nxt; // R2
			neg_r <= neg_nxt; // R2
			analog_ground_r <= analog_ground_nxt; // R2
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result ready flag; a new result wins over a simultaneous data read.
	// A result that finishes while the filter is being flushed is stale and
	// is not flagged.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ready_r <= 1'b0; // R9
		end else if (conv_done && state_r == acs_pkg::ACS_CONV && !filter_reset_r) begin
			ready_r <= 1'b1; // R7
		end else if (data_read) begin
			ready_r <= 1'b0; // R8
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read port; reserved status bits read as zero.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_data_r <= 8'h00;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= register_read_cmd; // R11
			if (register_read_cmd) begin
				if (addr_hit(reg_addr, acs_pkg::ADDR_STATUS)) begin
					rd_data_r <= {ready_r, acs_pkg::STATUS_RSVD}; // R7 R10
				end else if (addr_hit(reg_addr, acs_pkg::ADDR_CONFIG)) begin
					rd_data_r <= config_r; // R1
				end else begin
					rd_data_r <= 8'h00;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Conversion control: a config write pulses the filter reset for a few
	// cycles and restarts any conversion in progress.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			flush_cnt_r <= 4'h0;
			filter_reset_r <= 1'b0;
		end else if (cfg_wr) begin
			flush_cnt_r <= acs_pkg::FLUSH_CYCLES; // R12
			filter_reset_r <= 1'b1; // R12
		end else if (flush_cnt_r != 4'h0) begin
			flush_cnt_r <= flush_cnt_r - 4'h1;
			filter_reset_r <= flush_cnt_r != 4'h1;
		end
	end

	// Conversion state. A power-down request during a single-shot conversion is only taken if
	// present in the cycle that conversion completes, and never in continuous mode; the start
	// command leaves power-down with the configuration untouched.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_r <= acs_pkg::ACS_IDLE;
		end else begin
			unique case (state_r)
				acs_pkg::ACS_IDLE: begin
					if (start_cmd) begin
						state_r <= acs_pkg::ACS_CONV;
					end else if (powerdown_cmd) begin
						state_r <= acs_pkg::ACS_OFF;
					end
				end
				acs_pkg::ACS_CONV: begin
					if (conv_done && !filter_reset_r && !config_r[acs_pkg::MODE_BIT]) begin
						state_r <= powerdown_cmd ? acs_pkg::ACS_OFF : acs_pkg::ACS_IDLE; // R5
					end
				end
				acs_pkg::ACS_OFF: begin
					if (start_cmd) begin
						state_r <= acs_pkg::ACS_CONV; // R13
					end
				end
				default: begin
					state_r <= acs_pkg::ACS_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			input_select <= 3'h0;
			gain_four <= 1'b0;
			rate_select <= 2'h0;
			conversion_mode_select <= 1'b0;
			ref_external <= 1'b0;
			converting <= 1'b0;
			powered_down <= 1'b0;
		end else begin
			input_select <= config_r[acs_pkg::SEL_HI:acs_pkg::SEL_LO]; // R2
			gain_four <= config_r[acs_pkg::GAIN_BIT]; // R3
			rate_select <= config_r[acs_pkg::RATE_HI:acs_pkg::RATE_LO]; // R4
			conversion_mode_select <= config_r[acs_pkg::MODE_BIT]; // R5
			ref_external <= config_r[acs_pkg::REF_BIT]; // R6
			converting <= state_r == acs_pkg::ACS_CONV;
			powered_down <= state_r == acs_pkg::ACS_OFF;
		end
	end

	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign filter_reset = filter_reset_r;
	assign result_ready_flag = ready_r;
	assign positive_input = pos_r;
	assign negative_input = neg_r;
	assign to_analog_ground = analog_ground_r;
endmodule

// [tb/acs_monitor.sv]
`timescale 1ns/10ps
module acs_monitor(input wire logic mclk, reset, register_read_cmd, register_write_cmd, rd_valid,
	input wire logic filter_reset, conv_done, data_read, result_ready_flag, to_analog_ground,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] wr_data, rd_data,
	input wire logic [2:0] input_select,
	input wire logic [1:0] positive_input, negative_input);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	wire cw = register_write_cmd && reg_addr == 4'h0;
	rdv_resp_a: assert property (register_read_cmd |=> rd_valid) else $error("read not answered");
	rdv_cause_a: assert property (rd_valid |-> $past(register_read_cmd)) else $error("stray read answer");
	stat_read_a: assert property (register_read_cmd && reg_addr == 4'h1
		|=> rd_data == {$past(result_ready_flag), 7'h00}) else $error("bad status read");
	unmap_read_a: assert property (register_read_cmd && reg_addr > 4'h1 |=> rd_data == 8'h00)
		else $error("bad unmapped read");
	cfg_apply_a: assert property (cw ##1 !cw |-> ##1 input_select == $past(wr_data[7:5], 2))
		else $error("field not applied");
	flush_len_a: assert property (cw |=> filter_reset [*2]) else $error("flush too short");
	ready_src_a: assert property ($rose(result_ready_flag) |-> $past(conv_done)) else $error("stray ready");
	ready_clr_a: assert property (data_read && !conv_done |=> !result_ready_flag)
		else $error("ready not cleared");
	mux_diff_a: assert property ((input_select == 3'h1) [*2] |-> positive_input == 2'h2
		&& negative_input == 2'h3) else $error("bad pair decode");
	mux_gnd_a: assert property ((input_select == 3'h4) [*2] |-> to_analog_ground
		&& positive_input == 2'h1) else $error("bad single decode");
	cover property (result_ready_flag);
	cover property (filter_reset);
	cover property (rd_valid);
endmodule
bind acs_regs acs_monitor u_mon(.*);

// [tb/acs_conv_model.sv]
`timescale 1ns/10ps
module acs_conv_model(input wire logic mclk, reset, converting, output logic conv_done);
	logic [2:0] cnt_r;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_r <= 3'h0;
			conv_done <= 1'b0;
		end else begin
			cnt_r <= converting ? cnt_r + 3'h1 : 3'h0;
			conv_done <= converting && cnt_r == 3'h5;
		end
	end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	logic mclk = 0, reset = 1, register_read_cmd = 0, register_write_cmd = 0;
	logic data_read = 0, start_cmd = 0, powerdown_cmd = 0, conv_done, rd_valid, to_analog_ground, gain_four;
	logic conversion_mode_select, ref_external, filter_reset, converting, powered_down, result_ready_flag;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] wr_data = 8'h00, rd_data, got;
	logic [2:0] input_select;
	logic [1:0] positive_input, negative_input, rate_select;
	int miscompares = 0, num_checks = 0;
	logic [10:0] rows [8] = '{11'h000, 11'h12C, 11'h252, 11'h3E1, 11'h49B, 11'h545, 11'h6B7, 11'h7FF};
	acs_regs u_dut(.*);
	acs_conv_model u_conv(.*);
	always #2.5 mclk = ~mclk;
	task chk(input string n, input logic [7:0] e, g);
		num_checks++;
		if (e !== g) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		register_write_cmd <= 1'b1;
		reg_addr <= a;
		wr_data <= d;
		@(posedge mclk);
		register_write_cmd <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge mclk);
		register_read_cmd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		register_read_cmd <= 1'b0;
		got = 8'hEE;
		@(posedge mclk);
		if (rd_valid === 1'b1) got = rd_data;
	endtask
	task complete_run;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		cyc(2);
		chk("sel", 8'h01, {3'h0, input_select, negative_input});
		chk("ready", 8'h00, {7'h00, result_ready_flag});
		rd(4'h0);
		chk("cfg", 8'h00, got);
		for (int i = 0; i < 8; i++) begin
			wr(4'h0, rows[i][10:3]);
			cyc(3);
			chk("fld", rows[i][10:3], {input_select, gain_four, rate_select, conversion_mode_select, ref_external});
			chk("mux", {5'h00, rows[i][2:0]}, {5'h00, positive_input, to_analog_ground});
			rd(4'h0);
			chk("cfg", rows[i][10:3], got);
		end
		wr(4'h1, 8'h7F);
		rd(4'h0);
		chk("cfg", 8'hFF, got);
		rd(4'h1);
		chk("stat", 8'h00, got & 8'h80);
		rd(4'h5);
		chk("unmap", 8'h00, got);
		wr(4'h0, 8'h5C);
		cyc(4);
		start_cmd <= 1'b1;
		@(posedge mclk);
		start_cmd <= 1'b0;
		cyc(3);
		chk("conv", 8'h01, {7'h00, converting});
		cyc(9);
		chk("conv", 8'h00, {7'h00, converting});
		rd(4'h1);
		chk("stat", 8'h80, got & 8'h80);
		@(posedge mclk);
		data_read <= 1'b1;
		@(posedge mclk);
		data_read <= 1'b0;
		cyc(2);
		chk("ready", 8'h00, {7'h00, result_ready_flag});
		powerdown_cmd <= 1'b1;
		@(posedge mclk);
		powerdown_cmd <= 1'b0;
		cyc(3);
		chk("pdn", 8'h01, {7'h00, powered_down});
		rd(4'h0);
		chk("pd", 8'h5C, got);
		@(posedge mclk);
		reset <= 1'b1;
		cyc(2);
		reset <= 1'b0;
		cyc(2);
		chk("pdn", 8'h00, {7'h00, powered_down});
		chk("ready", 8'h00, {7'h00, result_ready_flag});
		rd(4'h0);
		chk("cfg", 8'h00, got);
		complete_run;
	end
endmodule
